// ### core/pin_mux_pkg.sv
// Constants and types for the port A pin function select block
package pin_mux_pkg;

  // APB register byte offsets
  localparam logic [7:0] DIR_OFF = 8'h00;
  localparam logic [7:0] DATA_OFF = 8'h04;
  localparam logic [7:0] LEVEL_OFF = 8'h08;
  localparam logic [7:0] SEL_OFF = 8'h0c;
  localparam logic [7:0] SWRST_OFF = 8'h10;
  localparam logic [7:0] CAUSE_OFF = 8'h14;

  // Implemented port A bits: 0 to 4 and 7
  localparam logic [7:0] PORT_MASK = 8'h9f;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Function select register layout
  localparam int SEL_PWM_LSB = 0;
  localparam int SEL_A4_LSB = 4;
  localparam int SEL_RPIN_BIT = 8;
  localparam logic [8:0] SEL_RST = 9'h000;
  localparam logic [8:0] SEL_MASK = 9'h13f;

  // Software reset request bit
  localparam int SWRST_BIT = 0;

  // Internal reset release delay in clock cycles
  localparam int RST_RELEASE_CYCLES = 32;
  localparam int RST_CNT_W = 6;

  // Pin input synchroniser reset level (pins idle high on pull-ups)
  localparam logic [5:0] SYNC_RST = 6'h3f;

  // Function of port A bit 4
  typedef enum logic [1:0] {
    A4_GPIO = 2'b00,
    A4_PWM = 2'b01,
    A4_TIMER = 2'b10,
    A4_FAULT = 2'b11
  } a4_func_t;

  // Cause of the last chip reset
  typedef enum logic [1:0] {
    CAUSE_POR = 2'b00,
    CAUSE_PIN = 2'b01,
    CAUSE_WDOG = 2'b10,
    CAUSE_SW = 2'b11
  } rst_cause_t;

  // Reset sequencer states
  typedef enum logic [1:0] {
    RS_HOLD = 2'b00,
    RS_COUNT = 2'b01,
    RS_RUN = 2'b10
  } rst_state_t;

  // Open-drain enable: drive low only when output and data is zero
  function automatic logic od_oe_n(input logic dir, input logic data);
    od_oe_n = !(dir && !data);
  endfunction

endpackage

// ### core/port_a_pin_function_select.sv
// Port A pin function select with reset pin handling and APB registers
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - After any reset every pin is in its primary function until software selects.
// - Reset pin low initialises the chip and holds it in reset.
// - Internal reset releases synchronously after a fixed number of clock cycles.
// - Reset pin as port A bit 7 is input or open-drain only, never high.
// - After reset the shared pin comes up as external reset.
// - Each GPIO pin has its own software direction, input or output.
// - Port A bits 0 to 4 offer PWM channels 0 to 4.
// - Bit 4 as fault input 1 feeds the PWM fault logic.
// - Bit 4 also offers bidirectional timer A channel 2, chosen by selection.
// - Port A bits 0 to 4 default to GPIO after reset.
module port_a_pin_function_select
  import pin_mux_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources and result
  input wire logic watchdog_reset,
  output logic chip_rst_n,
  // Port A bits 0 to 4 pads
  input wire logic [4:0] port_a_pad_in,
  output logic [4:0] port_a_pad_out,
  output logic [4:0] port_a_pad_oe_n,
  // Reset pin, also port_a_bit7_on_reset_pin
  input wire logic reset_pad_in,
  output logic reset_pad_out,
  output logic reset_pad_oe_n,
  // PWM peripheral
  input wire logic [4:0] motor_pwm_out,
  input wire logic [4:0] motor_pwm_oe,
  output logic pwm_fault_input_1,
  // Timer A channel 2
  input wire logic timer_a_channel_2_out,
  input wire logic timer_a_channel_2_oe,
  output logic timer_a_channel_2_in
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reset_ctl_if rc ();

  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic [4:0] pin_lvl;
  logic rpin_lvl;

  logic [7:0] dir_q;
  logic [7:0] data_q;
  logic [8:0] sel_q;
  logic sw_rst_q;
  logic rpin_gpio;
  a4_func_t a4_func;

  logic setup;
  logic wr_en;
  logic wr_dir;
  logic wr_data;
  logic wr_sel;
  logic wr_swrst;
  logic [31:0] rdata_d;
  logic hit_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic [4:0] pad_out_d;
  logic [4:0] pad_oe_n_d;
  logic [4:0] pad_out_q;
  logic [4:0] pad_oe_n_q;
  logic rpad_oe_n_d;
  logic rpad_oe_n_q;
  logic fault_q;
  logic timer_in_q;

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
    end else begin
      meta_q <= {reset_pad_in, port_a_pad_in};
      sync_q <= meta_q;
    end
  end

  assign pin_lvl = sync_q[4:0];
  assign rpin_lvl = sync_q[5];

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  assign rpin_gpio = sel_q[SEL_RPIN_BIT];
  assign a4_func = a4_func_t'(sel_q[SEL_A4_LSB +: 2]);

  always_comb begin
    rc.hold_req = (!rpin_gpio && !rpin_lvl) || watchdog_reset || sw_rst_q;
    if (!rpin_gpio && !rpin_lvl) begin
      rc.req_cause = CAUSE_PIN;
    end else if (watchdog_reset) begin
      rc.req_cause = CAUSE_WDOG;
    end else begin
      rc.req_cause = CAUSE_SW;
    end
  end

  reset_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .rc(rc.seq)
  );

  assign chip_rst_n = rc.chip_rst_n;

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite;

  always_comb begin
    rdata_d = '0;
    hit_d = 1'b1;
    case (paddr)
      DIR_OFF: rdata_d[7:0] = dir_q;
      DATA_OFF: rdata_d[7:0] = data_q;
      LEVEL_OFF: rdata_d[7:0] = {rpin_lvl, 2'b00, pin_lvl};
      SEL_OFF: rdata_d[8:0] = sel_q;
      SWRST_OFF: rdata_d = '0;
      CAUSE_OFF: rdata_d[1:0] = rc.last_cause;
      default: hit_d = 1'b0;
    endcase
  end

  // One access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= setup && !hit_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else begin
      if (setup && !pwrite) begin
        prdata_q <= rdata_d;
      end else if (!setup) begin
        prdata_q <= '0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------
  // Register write strobes
  // ----------------------------------------
  assign wr_dir = wr_en && (paddr == DIR_OFF);
  assign wr_data = wr_en && (paddr == DATA_OFF);
  assign wr_sel = wr_en && (paddr == SEL_OFF);
  assign wr_swrst = wr_en && (paddr == SWRST_OFF);

  // ----------------------------------------
  // Direction and data registers
  // ----------------------------------------
  // Per-pin direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= DIR_RST;
    end else if (!rc.chip_rst_n) begin
      dir_q <= DIR_RST;
    end else if (wr_dir) begin
      dir_q <= pwdata[7:0] & PORT_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= DATA_RST;
    end else if (!rc.chip_rst_n) begin
      data_q <= DATA_RST;
    end else if (wr_data) begin
      data_q <= pwdata[7:0] & PORT_MASK;
    end
  end

  // ----------------------------------------
  // Function select register
  // ----------------------------------------
  // Primary functions until written
  // Bits 0 to 4 start as GPIO
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= SEL_RST;
    end else if (!rc.chip_rst_n) begin
      sel_q <= SEL_RST;
    end else if (wr_sel) begin
      sel_q <= pwdata[8:0] & SEL_MASK;
    end
  end

  // ----------------------------------------
  // Software reset request
  // ----------------------------------------
  // Software reset source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_rst_q <= 1'b0;
    end else if (wr_swrst && pwdata[SWRST_BIT]) begin
      sw_rst_q <= 1'b1;
    end else if (!rc.chip_rst_n) begin
      sw_rst_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pad output selection
  // ----------------------------------------
  always_comb begin
    pad_out_d = data_q[4:0];
    pad_oe_n_d = ~dir_q[4:0];
    for (int i = 0; i < 4; i++) begin
      if (sel_q[SEL_PWM_LSB + i]) begin
        pad_out_d[i] = motor_pwm_out[i];
        pad_oe_n_d[i] = !motor_pwm_oe[i];
      end
    end
    case (a4_func)
      A4_GPIO: begin
        pad_out_d[4] = data_q[4];
        pad_oe_n_d[4] = !dir_q[4];
      end
      A4_PWM: begin
        pad_out_d[4] = motor_pwm_out[4];
        pad_oe_n_d[4] = !motor_pwm_oe[4];
      end
      A4_TIMER: begin
        pad_out_d[4] = timer_a_channel_2_out;
        pad_oe_n_d[4] = !timer_a_channel_2_oe;
      end
      A4_FAULT: begin
        pad_out_d[4] = 1'b0;
        pad_oe_n_d[4] = 1'b1;
      end
      default: begin
        pad_out_d[4] = 1'b0;
        pad_oe_n_d[4] = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out_q <= '0;
      pad_oe_n_q <= '1;
    end else begin
      pad_out_q <= pad_out_d;
      pad_oe_n_q <= pad_oe_n_d;
    end
  end

  assign port_a_pad_out = pad_out_q;
  assign port_a_pad_oe_n = pad_oe_n_q;

  // ----------------------------------------
  // Reset pin as open-drain port A bit 7
  // ----------------------------------------
  // Never drives high
  assign rpad_oe_n_d = !rpin_gpio || od_oe_n(dir_q[7], data_q[7]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpad_oe_n_q <= 1'b1;
    end else begin
      rpad_oe_n_q <= rpad_oe_n_d;
    end
  end

  assign reset_pad_out = 1'b0;
  assign reset_pad_oe_n = rpad_oe_n_q;

  // ----------------------------------------
  // Peripheral inputs from bit 4
  // ----------------------------------------
  // Fault level to PWM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= (a4_func == A4_FAULT) && pin_lvl[4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_in_q <= 1'b0;
    end else begin
      timer_in_q <= (a4_func == A4_TIMER) && pin_lvl[4];
    end
  end

  assign pwm_fault_input_1 = fault_q;
  assign timer_a_channel_2_in = timer_in_q;

endmodule

// ### core/reset_ctl_if.sv
// Signals between the pin mux and its reset sequencer
`timescale 1ns/1ps
interface reset_ctl_if;
  import pin_mux_pkg::*;
  logic hold_req;
  rst_cause_t req_cause;
  logic chip_rst_n;
  rst_cause_t last_cause;

  modport seq (
    input hold_req,
    input req_cause,
    output chip_rst_n,
    output last_cause
  );

  modport ctl (
    output hold_req,
    output req_cause,
    input chip_rst_n,
    input last_cause
  );
endinterface

// ### core/reset_sequencer.sv
// Holds the chip in reset and releases it after a fixed cycle count
`timescale 1ns/1ps
module reset_sequencer
  import pin_mux_pkg::*;
(
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // Reset control
  reset_ctl_if.seq rc
);

  rst_state_t state_q;
  logic [RST_CNT_W-1:0] cnt_q;
  logic chip_rst_n_q;
  rst_cause_t cause_q;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Synchronous counted release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RS_HOLD;
      cnt_q <= '0;
      chip_rst_n_q <= 1'b0;
    end else begin
      case (state_q)
        RS_HOLD: begin
          cnt_q <= '0;
          if (!rc.hold_req) begin
            state_q <= RS_COUNT;
          end
        end
        RS_COUNT: begin
          if (rc.hold_req) begin
            state_q <= RS_HOLD;
          end else if (cnt_q == RST_CNT_W'(RST_RELEASE_CYCLES - 1)) begin
            state_q <= RS_RUN;
            chip_rst_n_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        RS_RUN: begin
          if (rc.hold_req) begin
            state_q <= RS_HOLD;
            chip_rst_n_q <= 1'b0;
          end
        end
        default: begin
          state_q <= RS_HOLD;
          chip_rst_n_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Reset cause, kept across chip resets
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= CAUSE_POR;
    end else if (state_q == RS_RUN && rc.hold_req) begin
      cause_q <= rc.req_cause;
    end
  end

  assign rc.chip_rst_n = chip_rst_n_q;
  assign rc.last_cause = cause_q;

endmodule

// ### test/periph_model.sv
// Stand-in for the PWM and timer peripherals
`timescale 1ns/1ps
module periph_model (
  // Clock
  input wire logic pclk,
  // Peripheral drive
  output logic [4:0] motor_pwm_out,
  output logic [4:0] motor_pwm_oe,
  output logic timer_a_channel_2_out,
  output logic timer_a_channel_2_oe
);
  logic [7:0] cnt_q = 8'h00;
  // New pattern every cycle
  always_ff @(posedge pclk) begin
    cnt_q <= cnt_q * 8'h05 + 8'h3b;
  end
  assign motor_pwm_out = cnt_q[4:0];
  assign motor_pwm_oe = cnt_q[7:3];
  assign timer_a_channel_2_out = cnt_q[1];
  assign timer_a_channel_2_oe = cnt_q[6];
endmodule

// ### test/port_a_pin_function_select_sva.sv
// Checker for the port A pin function select ports
`timescale 1ns/1ps
module pin_sel_sva
  import pin_mux_pkg::*;
(
  // Clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Reset and pads
  input wire logic watchdog_reset,
  input wire logic chip_rst_n,
  input wire logic [4:0] port_a_pad_in,
  input wire logic [4:0] port_a_pad_out,
  input wire logic [4:0] port_a_pad_oe_n,
  input wire logic reset_pad_out,
  input wire logic reset_pad_oe_n,
  // Peripherals
  input wire logic [4:0] motor_pwm_out,
  input wire logic [4:0] motor_pwm_oe,
  input wire logic pwm_fault_input_1,
  input wire logic timer_a_channel_2_out,
  input wire logic timer_a_channel_2_in
);
  logic [8:0] sel_q;
  logic [4:0] pm;
  // ----
  // Selection shadow
  // ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sel_q <= SEL_RST;
    else if (!chip_rst_n) sel_q <= SEL_RST;
    else if (psel && penable && pready && pwrite && paddr == SEL_OFF) sel_q <= pwdata[8:0] & SEL_MASK;
  end
  assign pm = {sel_q[5:4] == 2'b01, sel_q[3:0]};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_prim;
    !chip_rst_n [*2] |=> port_a_pad_oe_n == 5'h1f && !pwm_fault_input_1;
  endproperty
  a_prim: assert property (p_prim)
    else $error("pads driven in chip reset");
  property p_odr;
    !reset_pad_oe_n |-> reset_pad_out == 1'b0 && $past(sel_q[SEL_RPIN_BIT]);
  endproperty
  a_odr: assert property (p_odr)
    else $error("reset pin driven outside open-drain port mode");
  property p_wdg;
    watchdog_reset |-> ##[1:2] !chip_rst_n;
  endproperty
  a_wdg: assert property (p_wdg)
    else $error("watchdog did not reset");
  property p_rel;
    $fell(watchdog_reset) |-> !chip_rst_n [*8] ##25 !chip_rst_n ##1 chip_rst_n;
  endproperty
  a_rel: assert property (p_rel)
    else $error("reset release count wrong");
  property p_pwm;
    chip_rst_n && |pm |=> (port_a_pad_out & $past(pm)) == ($past(motor_pwm_out) & $past(pm));
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("pwm value not routed");
  property p_poe;
    chip_rst_n && |pm |=> (~port_a_pad_oe_n & $past(pm)) == ($past(motor_pwm_oe) & $past(pm));
  endproperty
  a_poe: assert property (p_poe)
    else $error("pwm enable not routed");
  property p_tmr;
    chip_rst_n && sel_q[5:4] == 2'b10 |=> port_a_pad_out[4] == $past(timer_a_channel_2_out);
  endproperty
  a_tmr: assert property (p_tmr)
    else $error("timer value not routed");
  property p_tin;
    (chip_rst_n && sel_q[5:4] == 2'b10) [*4] |-> timer_a_channel_2_in == $past(port_a_pad_in[4], 3);
  endproperty
  a_tin: assert property (p_tin)
    else $error("timer input not routed");
  property p_flt;
    (chip_rst_n && sel_q[5:4] == 2'b11) [*4] |-> pwm_fault_input_1 == $past(port_a_pad_in[4], 3);
  endproperty
  a_flt: assert property (p_flt)
    else $error("fault input not routed");
  property p_flt0;
    sel_q[5:4] != 2'b11 |=> !pwm_fault_input_1;
  endproperty
  a_flt0: assert property (p_flt0)
    else $error("fault seen while not selected");
  c_wdg: cover property (watchdog_reset ##2 !chip_rst_n);
  c_pwm: cover property (chip_rst_n && pm[4]);
  c_flt: cover property (sel_q[5:4] == 2'b11 && pwm_fault_input_1);
endmodule
bind port_a_pin_function_select pin_sel_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .watchdog_reset, .chip_rst_n, .port_a_pad_in, .port_a_pad_out, .port_a_pad_oe_n, .reset_pad_out,
  .reset_pad_oe_n, .motor_pwm_out, .motor_pwm_oe, .pwm_fault_input_1, .timer_a_channel_2_out,
  .timer_a_channel_2_in);

// ### test/port_a_pin_function_select_tb_top.sv
// Self-checking bench for the port A pin function select
`timescale 1ns/1ps
module port_a_pin_function_select_tb_top;
  import pin_mux_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, watchdog_reset, chip_rst_n, lerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [4:0] port_a_pad_in, port_a_pad_out, port_a_pad_oe_n, motor_pwm_out, motor_pwm_oe, pad_rnd, pwm_d, oe_d;
  logic reset_pad_in, reset_pad_out, reset_pad_oe_n, rpin_drv, pwm_fault_input_1, t_d, toe_d;
  logic timer_a_channel_2_out, timer_a_channel_2_oe, timer_a_channel_2_in;
  int num_errors = 0, n_compared = 0, cyc = 0, dir_m, data_m, sel_m;
  // Wire levels with pull-up on the reset pin
  assign port_a_pad_in = (port_a_pad_out & ~port_a_pad_oe_n) | (pad_rnd & port_a_pad_oe_n);
  assign reset_pad_in = reset_pad_oe_n ? rpin_drv : reset_pad_out;
  port_a_pin_function_select u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .watchdog_reset, .chip_rst_n, .port_a_pad_in, .port_a_pad_out, .port_a_pad_oe_n,
    .reset_pad_in, .reset_pad_out, .reset_pad_oe_n, .motor_pwm_out, .motor_pwm_oe, .pwm_fault_input_1,
    .timer_a_channel_2_out, .timer_a_channel_2_oe, .timer_a_channel_2_in);
  periph_model u_periph (.pclk, .motor_pwm_out, .motor_pwm_oe, .timer_a_channel_2_out, .timer_a_channel_2_oe);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    pad_rnd <= 5'($urandom);
    pwm_d <= motor_pwm_out;
    oe_d <= motor_pwm_oe;
    t_d <= timer_a_channel_2_out;
    toe_d <= timer_a_channel_2_oe;
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      results;
    end
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rv);
    chk(rv, e);
  endtask
  task automatic wrun;
    while (chip_rst_n !== 1'b1) begin
      @(posedge pclk);
    end
    @(posedge pclk);
  endtask
  task automatic pads;
    logic [4:0] o, e;
    #1;
    o = data_m[4:0];
    e = dir_m[4:0];
    for (int i = 0; i < 4; i++) begin
      if (sel_m[i]) begin
        o[i] = pwm_d[i];
        e[i] = oe_d[i];
      end
    end
    case (sel_m[5:4])
      2'd1: {o[4], e[4]} = {pwm_d[4], oe_d[4]};
      2'd2: {o[4], e[4]} = {t_d, toe_d};
      2'd3: e[4] = 1'b0;
      default: ;
    endcase
    chk(32'(port_a_pad_oe_n), {27'h0, ~e});
    chk(32'(port_a_pad_out & e), 32'(o & e));
    @(posedge pclk);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(79658));
    {presetn, psel, penable, pwrite, watchdog_reset} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rpin_drv = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (32) @(posedge pclk);
    #1;
    chk(chip_rst_n, 1'b0);
    @(posedge pclk);
    #1;
    chk(chip_rst_n, 1'b1);
    chk(reset_pad_oe_n, 1'b1);
    @(posedge pclk);
    {dir_m, data_m, sel_m} = '0;
    pads;
    rdc(SEL_OFF, 32'h0);
    rdc(8'h40, 32'h0);
    chk(lerr, 1'b1);
    for (int k = 0; k < 8; k++) begin
      dir_m = $urandom;
      data_m = $urandom;
      sel_m = ($urandom & 'hf) | ((k & 3) << 4);
      apb(1'b1, DIR_OFF, dir_m, rv);
      apb(1'b1, DATA_OFF, data_m, rv);
      apb(1'b1, SEL_OFF, sel_m, rv);
      pads;
    end
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, SEL_OFF, 32'h3f, rv);
      if (s == 0) rpin_drv <= 1'b0;
      if (s == 1) watchdog_reset <= 1'b1;
      if (s == 2) apb(1'b1, SWRST_OFF, 32'h1, rv);
      repeat (6) @(posedge pclk);
      chk(chip_rst_n, 1'b0);
      rpin_drv <= 1'b1;
      watchdog_reset <= 1'b0;
      wrun;
      rdc(CAUSE_OFF, s + 1);
      rdc(SEL_OFF, 32'h0);
    end
    apb(1'b1, DIR_OFF, 32'h80, rv);
    apb(1'b1, SEL_OFF, 32'h100, rv);
    repeat (2) @(posedge pclk);
    chk(reset_pad_oe_n, 1'b0);
    apb(1'b1, DATA_OFF, 32'h80, rv);
    repeat (2) @(posedge pclk);
    chk(reset_pad_oe_n, 1'b1);
    rpin_drv <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(chip_rst_n, 1'b1);
    // Pads driven from data, reset pin released high
    rpin_drv <= 1'b1;
    apb(1'b1, DIR_OFF, 32'h9f, rv);
    apb(1'b1, DATA_OFF, 32'h95, rv);
    repeat (3) @(posedge pclk);
    rdc(LEVEL_OFF, 32'h95);
    results;
  end
endmodule
